// ==== inc/mii_pkg.sv ====
package mii_pkg;
    // system clock and nominal link clock periods
    localparam int CLK_PERIOD_NS = 100;
    localparam int LINK_PERIOD_10_NS = 400;
    localparam int LINK_PERIOD_100_NS = 40;
    // half period in system cycles, rounded down, never below one
    localparam int HALF_10_INT = (LINK_PERIOD_10_NS / 2) / CLK_PERIOD_NS;
    localparam int HALF_100_INT = (LINK_PERIOD_100_NS / 2) / CLK_PERIOD_NS;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] HALF_10 =
        (HALF_10_INT < 1) ? DIV_W'(1) : DIV_W'(HALF_10_INT);
    localparam logic [DIV_W-1:0] HALF_100 =
        (HALF_100_INT < 1) ? DIV_W'(1) : DIV_W'(HALF_100_INT);
    localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
    localparam logic [DIV_W-1:0] DIV_ONE = 4'h1;
    // nibble and receive buffer layout
    localparam int NIB_W = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int RXW_ERR = NIB_W;
    localparam int RXW_EOF = NIB_W + 1;
    localparam int RXW_W = NIB_W + 2;
    localparam logic [NIB_W-1:0] NIB_IDLE = 4'h0;
    // receive clock source
    typedef enum logic {SRC_LOCAL, SRC_RECOVERED} rx_src_t;
endpackage

// ==== inc/mii_if.sv ====
`timescale 1ns/1ns
interface mii_if;
    import mii_pkg::*;
    logic tx_clk;
    logic rx_clk;
    logic tx_en;
    logic [NIB_W-1:0] txd;
    logic tx_er;
    logic rx_dv;
    logic [NIB_W-1:0] rxd;
    logic rx_er;

    modport phy (
        output tx_clk, rx_clk, rx_dv, rxd, rx_er,
        input tx_en, txd, tx_er
    );
    modport mac (
        input tx_clk, rx_clk, rx_dv, rxd, rx_er,
        output tx_en, txd, tx_er
    );
endinterface // mii_if

// ==== rtl/nib_fifo.sv ====
`timescale 1ns/1ns
module nib_fifo import mii_pkg::*; #(
    parameter int WIDTH = RXW_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock, // system clock
    input wire logic srst, // sync reset, high
    input wire logic in_valid, // write offered
    output logic in_ready, // room left
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data, // head word
    output logic full // no room
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////
    // handshakes; full refuses writes so the source stalls
    assign full = (count_r == CNT_FULL);
    assign in_ready = ~full;
    assign out_valid = (count_r != CNT_ZERO);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // storage, no reset needed on data
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge clock) begin
        if (srst) begin
            count_r <= '0;
        end else if (push & ~pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop & ~push) begin
            count_r <= count_r - 1'b1;
        end
    end
endmodule // nib_fifo

// ==== rtl/mii_phy_end.sv ====
// Overview of operation
// RQ1: transmit clock is quarter bit rate, balanced; at 100 Mb/s the code gives a 200 ns period, not 40 ns
// RQ2: receive clock quarter rate, phases at least 35%; at 100 Mb/s the code gives a 200 ns period, not 40 ns; a switch to local can give a 25% phase
// RQ3: receive clock follows recovered data while receiving
// RQ4: signal lost: receive clock from local reference
// RQ5: switch source only with valid low, bounded phases
// RQ6: mac raises enable with first preamble nibble
// RQ7: mac keeps enable high for whole frame
// RQ8: mac drops enable right after last nibble
// RQ9: transmit data ignored while enable low
// RQ10: error with enable sends invalid symbol
// RQ11: transmit error ignored at 10 Mb/s
// RQ12: mac drives or pulls down transmit error
// RQ13: valid spans frame, drops right after it
// RQ14: mac ignores receive lines while valid low
// RQ15: receive error flags bad nibble, clock synchronous
// RQ16: receive error makes mac report check error
`timescale 1ns/1ns
module mii_phy_end import mii_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock, // system clock
    input wire logic srst, // sync reset, high
    mii_if.phy mii, // link toward the mac
    input wire logic speed100, // 1: 100 Mb/s, 0: 10 Mb/s
    output logic med_tx_valid, // one-cycle symbol strobe
    output logic [NIB_W-1:0] med_tx_data, // nibble to encode
    output logic med_tx_invalid, // send invalid code instead
    input wire logic med_sig_ok, // signal present, async pin
    input wire logic med_align, // recovered clock edge pulse
    input wire logic med_rx_valid, // recovered nibble offered
    output logic med_rx_ready, // buffer has room
    input wire logic [NIB_W-1:0] med_rx_data, // recovered nibble
    input wire logic med_rx_err, // decode error on nibble
    input wire logic med_rx_eof // last nibble of frame
);
    logic [DIV_W-1:0] half;
    logic [DIV_W-1:0] half_end;
    logic [DIV_W-1:0] tx_cnt_r;
    logic tx_clk_r;
    logic tx_tick;
    logic tx_rise;
    logic [DIV_W-1:0] rx_cnt_r;
    logic rx_clk_r;
    logic rx_tick;
    logic rx_fall;
    logic sig_meta_r;
    logic sig_ok_r;
    rx_src_t src_r;
    logic in_frame_r;
    logic rx_dv_r;
    logic [NIB_W-1:0] rxd_r;
    logic rx_er_r;
    logic buf_valid;
    logic buf_pop;
    logic buf_full;
    logic [RXW_W-1:0] buf_data;
    logic [RXW_W-1:0] buf_in;
    logic med_tx_valid_r;
    logic [NIB_W-1:0] med_tx_data_r;
    logic med_tx_invalid_r;

    ////////////////////////////////////////////////////////////////////
    // transmit clock divider
    assign half = speed100 ? HALF_100 : HALF_10;
    assign half_end = half - DIV_ONE;
    // >= so a speed change mid-phase cannot stretch the count
    assign tx_tick = (tx_cnt_r >= half_end);
    assign tx_rise = tx_tick & ~tx_clk_r;

    // equal halves give a 50% duty cycle at either speed
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_cnt_r <= DIV_ZERO;
            tx_clk_r <= 1'b0;
        end else if (tx_tick) begin
            tx_cnt_r <= DIV_ZERO;
            tx_clk_r <= ~tx_clk_r; // RQ1
        end else begin
            tx_cnt_r <= tx_cnt_r + DIV_ONE;
        end
    end

    assign mii.tx_clk = tx_clk_r;

    ////////////////////////////////////////////////////////////////////
    // transmit path toward the medium, sampled at the rising edge
    always_ff @(posedge clock) begin
        if (srst) begin
            med_tx_valid_r <= 1'b0;
            med_tx_data_r <= NIB_IDLE;
            med_tx_invalid_r <= 1'b0;
        end else begin
            med_tx_valid_r <= tx_rise & mii.tx_en; // RQ9
            if (tx_rise & mii.tx_en) begin
                med_tx_data_r <= mii.txd; // RQ9
                med_tx_invalid_r <= mii.tx_er & speed100; // RQ10 RQ11
            end
        end
    end

    assign med_tx_valid = med_tx_valid_r;
    assign med_tx_data = med_tx_data_r;
    assign med_tx_invalid = med_tx_invalid_r;

    ////////////////////////////////////////////////////////////////////
    // signal-present pin enters through two flops
    always_ff @(posedge clock) begin
        if (srst) begin
            sig_meta_r <= 1'b0;
            sig_ok_r <= 1'b0;
        end else begin
            sig_meta_r <= med_sig_ok;
            sig_ok_r <= sig_meta_r;
        end
    end

    // source changes only between frames, so no nibble is cut short
    always_ff @(posedge clock) begin
        if (srst) begin
            src_r <= SRC_LOCAL;
        end else if (~rx_dv_r & ~in_frame_r) begin // RQ5
            src_r <= sig_ok_r ? SRC_RECOVERED : SRC_LOCAL; // RQ3 RQ4
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive clock: own counter realigned on recovered edges, or
    // simply toggling with the local transmit reference
    assign rx_tick = (src_r == SRC_RECOVERED) ?
        (rx_cnt_r >= half_end) : tx_tick; // RQ4
    assign rx_fall = rx_tick & rx_clk_r;

    // realignment restarts a phase, lengthening it by under one half
    // period, well inside the two-period limit
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_cnt_r <= DIV_ZERO;
        end else if (rx_tick | med_align) begin
            rx_cnt_r <= DIV_ZERO; // RQ3 RQ5
        end else begin
            rx_cnt_r <= rx_cnt_r + DIV_ONE;
        end
    end

    // phases never shorter than one half period, except at a switch back to the local reference
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_clk_r <= 1'b0;
        end else if (rx_tick) begin
            rx_clk_r <= ~rx_clk_r; // RQ2
        end
    end

    assign mii.rx_clk = rx_clk_r;

    ////////////////////////////////////////////////////////////////////
    // recovered nibbles wait here until the receive clock takes them
    assign buf_in = {med_rx_eof, med_rx_err, med_rx_data};

    nib_fifo #(
        .WIDTH(RXW_W),
        .DEPTH(DEPTH)
    ) u_rx_buf (
        .clock(clock),
        .srst(srst),
        .in_valid(med_rx_valid),
        .in_ready(med_rx_ready),
        .in_data(buf_in),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(buf_data),
        .full(buf_full)
    );

    // a frame starts only once the buffer is full, which rides out
    // jitter; never right after a frame, so valid falls between them
    assign buf_pop = rx_fall & buf_valid & (in_frame_r |
        (buf_full & ~rx_dv_r & (src_r == SRC_RECOVERED))); // RQ13

    // frame tracking; an underrun ends the frame early
    always_ff @(posedge clock) begin
        if (srst) begin
            in_frame_r <= 1'b0;
        end else if (buf_pop) begin
            in_frame_r <= ~buf_data[RXW_EOF];
        end else if (rx_fall) begin
            in_frame_r <= 1'b0;
        end
    end

    // outputs change on the falling edge, stable at the rising one
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_dv_r <= 1'b0;
            rx_er_r <= 1'b0;
        end else if (rx_fall) begin
            rx_dv_r <= buf_pop; // RQ13
            rx_er_r <= buf_pop & buf_data[RXW_ERR]; // RQ15
        end
    end

    // data register holds its last value while valid is low
    always_ff @(posedge clock) begin
        if (srst) begin
            rxd_r <= NIB_IDLE;
        end else if (buf_pop) begin
            rxd_r <= buf_data[NIB_W-1:0];
        end
    end

    assign mii.rx_dv = rx_dv_r;
    assign mii.rxd = rxd_r;
    assign mii.rx_er = rx_er_r;
endmodule // mii_phy_end

// ==== rtl/mii_mac_end.sv ====
`timescale 1ns/1ns
module mii_mac_end import mii_pkg::*; (
    input wire logic clock, // system clock
    input wire logic srst, // sync reset, high
    mii_if.mac mii, // link toward the phy
    input wire logic tx_valid, // user nibble offered
    output logic tx_ready, // nibble taken this cycle
    input wire logic [NIB_W-1:0] tx_data, // nibble, preamble first
    input wire logic tx_err, // force coding error
    input wire logic tx_last, // last nibble of frame
    output logic rx_valid, // one-cycle nibble strobe
    output logic [NIB_W-1:0] rx_data, // received nibble
    output logic rx_end, // one-cycle end-of-frame strobe
    output logic rx_fcs_err // frame check error, with rx_end
);
    logic tx_clk_d_r;
    logic tx_fall;
    logic tx_en_r;
    logic [NIB_W-1:0] txd_r;
    logic tx_er_r;
    logic last_sent_r;
    logic rx_clk_d_r;
    logic rx_rise;
    logic rx_valid_r;
    logic [NIB_W-1:0] rx_data_r;
    logic in_rx_r;
    logic err_seen_r;
    logic rx_end_r;
    logic rx_fcs_err_r;

    ////////////////////////////////////////////////////////////////////
    // link clocks come from logic on this clock, so no synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_clk_d_r <= 1'b0;
            rx_clk_d_r <= 1'b0;
        end else begin
            tx_clk_d_r <= mii.tx_clk;
            rx_clk_d_r <= mii.rx_clk;
        end
    end

    assign tx_fall = tx_clk_d_r & ~mii.tx_clk;
    assign rx_rise = ~rx_clk_d_r & mii.rx_clk;

    ////////////////////////////////////////////////////////////////////
    // transmit: one nibble taken per falling edge of the link clock
    assign tx_ready = tx_fall & tx_valid;

    // an underrun mid-frame sends one errored nibble and stops,
    // since a gap in enable would be worse than a marked abort
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_en_r <= 1'b0;
            txd_r <= NIB_IDLE;
            tx_er_r <= 1'b0; // RQ12
        end else if (tx_fall) begin // RQ6
            if (tx_valid) begin
                tx_en_r <= 1'b1; // RQ6 RQ7
                txd_r <= tx_data;
                tx_er_r <= tx_err;
            end else if (tx_en_r & ~tx_er_r & ~last_sent_r) begin
                tx_en_r <= 1'b1; // RQ7
                txd_r <= NIB_IDLE;
                tx_er_r <= 1'b1;
            end else begin
                tx_en_r <= 1'b0; // RQ8
                txd_r <= NIB_IDLE;
                tx_er_r <= 1'b0; // RQ12
            end
        end
    end

    // marks a taken last nibble, so the gap after it is no underrun
    always_ff @(posedge clock) begin
        if (srst) begin
            last_sent_r <= 1'b0;
        end else if (tx_fall) begin
            last_sent_r <= tx_valid & tx_last;
        end
    end

    // registered drop only: an earlier one loses the last nibble at 100
    assign mii.tx_en = tx_en_r; // RQ8
    assign mii.txd = txd_r;
    assign mii.tx_er = tx_er_r;

    ////////////////////////////////////////////////////////////////////
    // receive: sampled on the rising edge, lines ignored without valid
    always_ff @(posedge clock) begin
        if (srst) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= NIB_IDLE;
        end else begin
            rx_valid_r <= rx_rise & mii.rx_dv; // RQ14
            if (rx_rise & mii.rx_dv) begin
                rx_data_r <= mii.rxd;
            end
        end
    end

    // error seen anywhere in a frame turns into a check error at end
    always_ff @(posedge clock) begin
        if (srst) begin
            in_rx_r <= 1'b0;
            err_seen_r <= 1'b0;
            rx_end_r <= 1'b0;
            rx_fcs_err_r <= 1'b0;
        end else begin
            rx_end_r <= 1'b0;
            rx_fcs_err_r <= 1'b0;
            if (rx_rise) begin
                in_rx_r <= mii.rx_dv;
                if (mii.rx_dv) begin
                    err_seen_r <= (err_seen_r & in_rx_r) | mii.rx_er;
                end else if (in_rx_r) begin
                    rx_end_r <= 1'b1;
                    rx_fcs_err_r <= err_seen_r; // RQ16
                end
            end
        end
    end

    assign rx_valid = rx_valid_r;
    assign rx_data = rx_data_r;
    assign rx_end = rx_end_r;
    assign rx_fcs_err = rx_fcs_err_r;
endmodule // mii_mac_end

// ==== tb/mii_link_checker.sv ====
`timescale 1ns/1ns
module mii_link_checker import mii_pkg::*; (
    input wire logic clock, // system clock
    input wire logic srst, // sync reset, high
    input wire logic tx_clk, // link transmit clock
    input wire logic rx_clk, // link receive clock
    input wire logic tx_en, // transmit enable
    input wire logic [NIB_W-1:0] txd, // transmit nibble
    input wire logic tx_er, // transmit error
    input wire logic rx_dv, // receive valid
    input wire logic [NIB_W-1:0] rxd, // receive nibble
    input wire logic rx_er // receive error
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    //////////////////////////////////////////////////////////////
    // transmit clock: half period is 1 or 2 cycles
    property p_tx_half;
        $changed(tx_clk) |-> ##[1:2] $changed(tx_clk);
    endproperty
    a_tx_half: assert property (p_tx_half)
        else $error("tx clock phase too long");
    // any phase at most twice the 4-cycle nominal period
    property p_rx_phase;
        $changed(rx_clk) |-> ##[1:8] $changed(rx_clk);
    endproperty
    a_rx_phase: assert property (p_rx_phase)
        else $error("rx clock phase over bound");
    // in a frame the source may not switch, so no stretched phase
    property p_rx_lock;
        rx_dv && $changed(rx_clk) |-> ##[1:3] $changed(rx_clk);
    endproperty
    a_rx_lock: assert property (p_rx_lock)
        else $error("rx clock stretched in frame");

    //////////////////////////////////////////////////////////////
    // transmit side moves only after a falling link edge
    property p_txd_sync;
        $changed(txd) || $changed(tx_er) |->
            $past(tx_clk, 2) && !$past(tx_clk);
    endproperty
    a_txd_sync: assert property (p_txd_sync)
        else $error("txd or tx_er off the link edge");
    // enable is a register, moving with the nibble
    property p_txen_sync;
        $changed(tx_en) |-> !$past(tx_clk) && $past(tx_clk, 2);
    endproperty
    a_txen_sync: assert property (p_txen_sync)
        else $error("tx_en off the link edge");
    property p_nib_hold;
        $changed(txd) |=> $stable(txd);
    endproperty
    a_nib_hold: assert property (p_nib_hold)
        else $error("nibble held under one period");
    property p_txer_idle;
        tx_er && !tx_en |=> !tx_er;
    endproperty
    a_txer_idle: assert property (p_txer_idle)
        else $error("tx_er left high while idle");

    //////////////////////////////////////////////////////////////
    // receive side moves with the falling receive edge
    property p_rx_sync;
        $changed(rx_dv) || $changed(rxd) |-> $fell(rx_clk);
    endproperty
    a_rx_sync: assert property (p_rx_sync)
        else $error("rx_dv or rxd off the link edge");
    property p_rxer_sync;
        $changed(rx_er) |-> $fell(rx_clk) && (rx_dv || !rx_er);
    endproperty
    a_rxer_sync: assert property (p_rxer_sync)
        else $error("rx_er off edge or outside frame");
endmodule // mii_link_checker

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import mii_pkg::*;
    localparam int DLY = 10;
    localparam logic [3:0] TD [7] = '{4'h5, 4'ha, 4'h3, 4'hd, 4'h6, 4'h9,
        4'h0};
    localparam logic [6:0] TE = 7'h44;
    localparam logic [3:0] RN [11] = '{4'h5, 4'h5, 4'hd, 4'h1, 4'h2, 4'h3,
        4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    localparam logic [10:0] RE = 11'h004;
    localparam logic [10:0] RL = 11'h420;
    logic clock, srst, speed100, med_sig_ok, med_align, s;
    logic med_rx_valid, med_rx_err, med_rx_eof, med_rx_ready;
    logic med_tx_valid, med_tx_invalid;
    logic [NIB_W-1:0] med_tx_data, med_rx_data, tx_data, rx_data;
    logic tx_valid, tx_ready, tx_err, tx_last, rx_valid, rx_end, rx_fcs_err;
    int err_total = 0, n_tests = 0, ntx = 0, nrx = 0, a, b;
    logic [4:0] txq[$];
    logic [3:0] rxq[$];
    logic fcsq[$];
    mii_if link ();

    mii_phy_end u_mii_phy_end (
        .clock(clock), .srst(srst), .mii(link), .speed100(speed100),
        .med_tx_valid(med_tx_valid), .med_tx_data(med_tx_data),
        .med_tx_invalid(med_tx_invalid), .med_sig_ok(med_sig_ok),
        .med_align(med_align), .med_rx_valid(med_rx_valid),
        .med_rx_ready(med_rx_ready), .med_rx_data(med_rx_data),
        .med_rx_err(med_rx_err), .med_rx_eof(med_rx_eof)
    );
    mii_mac_end u_mii_mac_end (
        .clock(clock), .srst(srst), .mii(link), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_err(tx_err),
        .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_end(rx_end), .rx_fcs_err(rx_fcs_err)
    );
    mii_link_checker u_mii_link_checker (
        .clock(clock), .srst(srst), .tx_clk(link.tx_clk),
        .rx_clk(link.rx_clk), .tx_en(link.tx_en), .txd(link.txd),
        .tx_er(link.tx_er), .rx_dv(link.rx_dv), .rxd(link.rxd),
        .rx_er(link.rx_er)
    );

    //////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clock = ~clock;
    end
    // strobes stand a whole cycle; look mid-cycle, away from the edge
    always @(negedge clock) begin
        if (med_tx_valid === 1'b1)
            txq.push_back({med_tx_invalid, med_tx_data});
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        if (rx_end === 1'b1)
            fcsq.push_back(rx_fcs_err);
    end
    always @(posedge link.tx_clk) ntx++;
    always @(posedge link.rx_clk) nrx++;

    //////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #DLY;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // valid stays up between nibbles; caller lowers it after the frame
    task automatic send(input logic [3:0] d, input logic e, input logic l);
        int k;
        {tx_valid, tx_data, tx_err, tx_last} = {1'b1, d, e, l};
        @(negedge clock);
        for (k = 0; k < 400 && tx_ready !== 1'b1; k++) @(negedge clock);
        cyc(1);
    endtask
    task automatic put(input logic [3:0] d, input logic e, input logic l);
        int k;
        {med_rx_valid, med_rx_data, med_rx_err, med_rx_eof} = {1'b1, d, e, l};
        @(negedge clock);
        for (k = 0; k < 400 && med_rx_ready !== 1'b1; k++) @(negedge clock);
        cyc(1);
    endtask
    task automatic complete_run;
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////
    // whole run is well under 1000 cycles; generous margin
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        complete_run();
    end
    initial begin
        {srst, speed100, med_sig_ok, med_align} = 4'h8;
        {med_rx_valid, med_rx_err, med_rx_eof} = 3'h0;
        {tx_valid, tx_err, tx_last, med_rx_data, tx_data} = 11'h000;
        cyc(8);
        srst = 1'b0;
        // both speeds, receive clock on local reference
        for (int i = 0; i < 2; i++) begin
            s = ~i[0];
            speed100 = s;
            cyc(8);
            a = ntx;
            b = nrx;
            cyc(40);
            chk(8'(ntx - a), s ? 8'h14 : 8'h0a);
            chk(8'(nrx - b), s ? 8'h14 : 8'h0a);
            txq.delete();
            for (int j = 0; j < 4; j++)
                send(TD[j], TE[j], j == 3);
            tx_valid = 1'b0;
            cyc(12);
            // underrun: frame stops without a last nibble
            send(TD[4], TE[4], 1'b0);
            send(TD[5], TE[5], 1'b0);
            tx_valid = 1'b0;
            cyc(16);
            chk(8'(txq.size()), 8'h07);
            for (int j = 0; j < 7; j++)
                chk(8'(txq[j]), {3'h0, TE[j] & s, TD[j]});
        end
        // local clock: buffer fills, no frame, a fifth nibble is refused
        for (int j = 0; j < 4; j++) begin
            put(RN[j], RE[j], RL[j]);
            chk({7'h00, med_rx_ready}, 8'(j < 3));
        end
        {med_rx_data, med_rx_err, med_rx_eof} = {RN[4], RE[4], RL[4]};
        cyc(4);
        chk({6'h00, med_rx_ready, link.rx_dv}, 8'h00);
        chk(8'(rxq.size()), 8'h00);
        // recovered source: two frames through the buffer, first errored
        med_sig_ok = 1'b1;
        for (int j = 4; j < 11; j++)
            put(RN[j], RE[j], RL[j]);
        med_rx_valid = 1'b0;
        cyc(80);
        chk({6'h00, med_rx_ready, link.rx_dv}, 8'h02);
        chk(8'(rxq.size()), 8'h0b);
        for (int j = 0; j < 11; j++)
            chk(8'(rxq[j]), 8'(RN[j]));
        chk(8'(fcsq.size()), 8'h02);
        chk(8'({fcsq[0], fcsq[1]}), 8'h02);
        // realigned recovered clock keeps the nominal rate between frames
        med_align = 1'b1;
        cyc(1);
        med_align = 1'b0;
        b = nrx;
        cyc(40);
        chk(8'(nrx - b), 8'h0a);
        complete_run();
    end
endmodule // tb_top
